// [shared/fsw_consts.svh]
// Purpose: Constants for the flash status register and write-enable gate
// Assumes: 20 MHz system clock, single-bit serial instructions
// Notes:   Opcodes are eight bits, sent most significant bit first
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// Timing
`define FSW_CLK_PERIOD_NS   50
`define FSW_OP_TIME_NS      50000
`define FSW_OP_CYCLES       (`FSW_OP_TIME_NS / `FSW_CLK_PERIOD_NS)

// Status register layout
`define FSW_BIT_BUSY        0
`define FSW_BIT_WEL         1
`define FSW_BIT_BP_LO       2
`define FSW_BIT_BP_HI       5
`define FSW_BIT_QE          6
`define FSW_BIT_LOCK        7
`define FSW_SR_FACTORY      6'h00
`define FSW_BP_NONE         4'h0

// Instructions handled directly
`define FSW_OP_WRITE_ENABLE_CMD         8'h06
`define FSW_OP_WRITE_DISABLE_CMD         8'h04
`define FSW_OP_STATUS_WRITE_CMD         8'h01
`define FSW_OP_RDSR         8'h05
`define FSW_OP_RDFR         8'h48
`define FSW_OP_SUSPEND      8'h75
`define FSW_OP_RESUME       8'h7a
`define FSW_OP_SOFT_RESET   8'h99

// Program and erase instructions
`define FSW_OP_PP           8'h02
`define FSW_OP_PP4          8'h12
`define FSW_OP_PPQ_A        8'h32
`define FSW_OP_PPQ_B        8'h38
`define FSW_OP_PPQ4_A       8'h34
`define FSW_OP_PPQ4_B       8'h3e
`define FSW_OP_SER_A        8'hd7
`define FSW_OP_SER_B        8'h20
`define FSW_OP_SER4         8'h21
`define FSW_OP_BLOCK32_ERASE_CMD        8'h52
`define FSW_OP_BLOCK32_ERASE_CMD_4      8'h5c
`define FSW_OP_BLOCK64_ERASE_CMD        8'hd8
`define FSW_OP_BLOCK64_ERASE_CMD_4      8'hdc
`define FSW_OP_CER_A        8'hc7
`define FSW_OP_CER_B        8'h60
`define FSW_OP_INFO_ROW_ERASE_CMD         8'h64
`define FSW_OP_IRP          8'h62

// Register and protection writes needing the latch
`define FSW_OP_FUNCTION_WRITE_CMD         8'h42
`define FSW_OP_RPNV         8'h65
`define FSW_OP_XRPNV        8'h85
`define FSW_OP_XRPV         8'h83
`define FSW_OP_BANKNV       8'h18
`define FSW_OP_DLW          8'hfb
`define FSW_OP_DLW_ALT      8'he1
`define FSW_OP_PLW          8'hfd
`define FSW_OP_PLW4         8'he3
`define FSW_OP_PLE          8'he4
`define FSW_OP_PMP          8'h2f
`define FSW_OP_LBW          8'ha6
`define FSW_OP_FRZ          8'h91
`define FSW_OP_GLOCK        8'h7e
`define FSW_OP_GUNLOCK      8'h98
`define FSW_OP_PWD          8'he8
`define FSW_OP_LPNV         8'h43
`define FSW_OP_LPV          8'h4a

`endif

// [shared/fsw_pkg.sv]
// Purpose: Types for the flash status register and write-enable gate
// Assumes: Constants live in fsw_consts.svh
// Notes:   Frame states are one-hot
package fsw_pkg;

   typedef logic [7:0] fsw_byte_t;

   typedef enum logic [3:0]
   {
      FSW_CMD  = 4'b0001,
      FSW_DATA = 4'b0010,
      FSW_READ = 4'b0100,
      FSW_SKIP = 4'b1000
   } fsw_frame_e;

endpackage

// [verilog/fsw_sync.sv]
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage; both reset to the pins' idle levels
`timescale 1ns/1ps
module fsw_sync
#(
   parameter int           W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // Two flops; metastability settles in the first
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// [verilog/fsw_status_wel.sv]
// Purpose: Status register, busy filter and write-enable gate of a serial flash
// Assumes: Mode 0 serial link, SCK slow enough to be sampled by CLK
// Notes:   Payloads other than the status write byte are not executed here; a busy timer stands in
//
// Function
// - A register read repeats the same byte until chip select rises.
// - Bit 0 is the volatile busy flag, 1 while an internal write runs.
// - Bit 1 is the volatile write-enable latch, 0 by default.
// - Bits 2 to 5 hold block-protect bits 0 to 3, default zero.
// - Bit 6 is the non-volatile quad-enable bit, default zero.
// - Bit 7 is the non-volatile status-write lock bit, default zero.
// - Protect, quad and lock bits start out cleared.
// - Status write updates protect, quad and lock in both copies.
// - Status write data never alters the write-enable latch bit.
// - Busy is read-only and high during any program, erase or register write.
// - While busy, only status or function reads, suspend and resets are taken.
// - Suspend is taken while a page program or a sector, block or chip erase runs.
// - Busy clears when the operation ends; instructions are then accepted.
// - Latch-gated instructions are refused while the latch is zero.
// - Write-enable sets the latch; hosts issue it before writes.
// - Write-disable clears the latch.
// - The latch clears itself when a program, erase or register write ends.
// - Page program forms need the latch.
// - Sector, block and chip erase forms need the latch.
// - Status, function and read-parameter register writes need the latch.
// - Information-row erase, program and bank register writes need the latch.
// - Sector protection commands need the latch.
// - Volatile read-parameter set and volatile bank write need no latch.
// - Lock bit set with write-protect low makes status writes ignored.
// - Chip erase is ignored unless all block-protect bits are zero.
`timescale 1ns/1ps
`include "fsw_consts.svh"
module fsw_status_wel
   import fsw_pkg::*;
#(
   parameter int OP_CYCLES = `FSW_OP_CYCLES,
   parameter int CNT_W     = 16
)
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST,
   // Serial link pins
   input  wire logic       SCK,
   input  wire logic       CS_N,
   input  wire logic       SI,
   input  wire logic       WP_N,
   output logic            SO,
   output logic            SO_OE,
   // Status view
   output logic [7:0]      STATUS
);

   // Latch-gated instruction set
   function automatic logic fsw_needs_wel(input fsw_byte_t op);
      logic r;
      r = 1'b0;
      unique case (op)
         `FSW_OP_PP, `FSW_OP_PP4, `FSW_OP_PPQ_A, `FSW_OP_PPQ_B,
         `FSW_OP_PPQ4_A, `FSW_OP_PPQ4_B: r = 1'b1;
         `FSW_OP_SER_A, `FSW_OP_SER_B, `FSW_OP_SER4, `FSW_OP_BLOCK32_ERASE_CMD,
         `FSW_OP_BLOCK32_ERASE_CMD_4, `FSW_OP_BLOCK64_ERASE_CMD, `FSW_OP_BLOCK64_ERASE_CMD_4,
         `FSW_OP_CER_A, `FSW_OP_CER_B: r = 1'b1;
         `FSW_OP_STATUS_WRITE_CMD, `FSW_OP_FUNCTION_WRITE_CMD, `FSW_OP_RPNV, `FSW_OP_XRPNV,
         `FSW_OP_XRPV: r = 1'b1;
         `FSW_OP_INFO_ROW_ERASE_CMD, `FSW_OP_IRP, `FSW_OP_BANKNV: r = 1'b1;
         `FSW_OP_DLW, `FSW_OP_DLW_ALT, `FSW_OP_PLW, `FSW_OP_PLW4,
         `FSW_OP_PLE, `FSW_OP_PMP, `FSW_OP_LBW, `FSW_OP_FRZ,
         `FSW_OP_GLOCK, `FSW_OP_GUNLOCK, `FSW_OP_PWD,
         `FSW_OP_LPNV, `FSW_OP_LPV: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Program and erase forms, the only suspendable operations
   function automatic logic fsw_is_prog_erase(input fsw_byte_t op);
      logic r;
      r = 1'b0;
      unique case (op)
         `FSW_OP_PP, `FSW_OP_PP4, `FSW_OP_PPQ_A, `FSW_OP_PPQ_B,
         `FSW_OP_PPQ4_A, `FSW_OP_PPQ4_B, `FSW_OP_SER_A, `FSW_OP_SER_B,
         `FSW_OP_SER4, `FSW_OP_BLOCK32_ERASE_CMD, `FSW_OP_BLOCK32_ERASE_CMD_4, `FSW_OP_BLOCK64_ERASE_CMD,
         `FSW_OP_BLOCK64_ERASE_CMD_4, `FSW_OP_CER_A, `FSW_OP_CER_B: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic fsw_is_chip_erase(input fsw_byte_t op);
      return (op == `FSW_OP_CER_A) || (op == `FSW_OP_CER_B);
   endfunction

   logic [3:0]       pins_s;
   logic             sck_s;
   logic             cs_n_s;
   logic             si_s;
   logic             wp_n_s;
   logic             sck_q;
   logic             cs_n_q;
   logic             sck_rise;
   logic             sck_fall;
   logic             cs_fall;
   logic             cs_end;
   fsw_frame_e       state;
   logic [2:0]       bit_cnt;
   logic [6:0]       shift;
   fsw_byte_t        next_byte;
   fsw_byte_t        opcode;
   fsw_byte_t        data_byte;
   logic             cmd_got;
   logic             data_got;
   logic [2:0]       rd_idx;
   fsw_byte_t        rd_latch;
   fsw_byte_t        rd_src;
   logic [5:0]       sr_nv;
   logic [5:0]       sr_vol;
   logic             wel;
   logic             write_busy_flag;
   logic             susp;
   logic             op_pe;
   logic [CNT_W-1:0] op_cnt;
   fsw_byte_t        status_now;
   logic             exec;
   logic             sr_locked;
   logic             accept_write_enable_cmd;
   logic             accept_write_disable_cmd;
   logic             soft_rst;
   logic             start_sr;
   logic             start_op;
   logic             do_susp;
   logic             do_resume;
   logic             op_done;

   // Pins cross into CLK through two flops each; select and protect reset high,
   // their idle level, so no false select edge follows reset
   fsw_sync #(.W(4), .RST_VAL(4'ha)) u_sync
   (
      .clk (CLK),
      .rst (RST),
      .d   ({WP_N, SI, CS_N, SCK}),
      .q   (pins_s)
   );

   assign sck_s  = pins_s[0];
   assign cs_n_s = pins_s[1];
   assign si_s   = pins_s[2];
   assign wp_n_s = pins_s[3];

   // Previous levels for edge detection; idle chip select is high
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end
      else
      begin
         sck_q  <= sck_s;
         cs_n_q <= cs_n_s;
      end
   end

   assign sck_rise  = sck_s & ~sck_q & ~cs_n_s;
   assign sck_fall  = ~sck_s & sck_q & ~cs_n_s;
   assign cs_fall   = ~cs_n_s & cs_n_q;
   assign cs_end    = cs_n_s & ~cs_n_q;
   assign next_byte = {shift, si_s};

   // Frame tracking: opcode, optional data byte, then read or skip
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state     <= FSW_CMD;
         bit_cnt   <= 3'h0;
         shift     <= 7'h00;
         opcode    <= 8'h00;
         data_byte <= 8'h00;
         cmd_got   <= 1'b0;
         data_got  <= 1'b0;
      end
      else if (cs_n_s)
      begin
         state   <= FSW_CMD;
         bit_cnt <= 3'h0;
      end
      else if (cs_fall)
      begin
         cmd_got  <= 1'b0;
         data_got <= 1'b0;
      end
      else if (sck_rise)
      begin
         shift   <= next_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7)
         begin
            unique case (state)
               FSW_CMD:
               begin
                  opcode  <= next_byte;
                  cmd_got <= 1'b1;
                  if (next_byte == `FSW_OP_RDSR || next_byte == `FSW_OP_RDFR)
                     state <= FSW_READ;
                  else if (next_byte == `FSW_OP_STATUS_WRITE_CMD)
                     state <= FSW_DATA;
                  else
                     state <= FSW_SKIP;
               end
               FSW_DATA:
               begin
                  data_byte <= next_byte;
                  data_got  <= 1'b1;
                  state     <= FSW_SKIP;
               end
               FSW_READ: state <= FSW_READ;
               FSW_SKIP: state <= FSW_SKIP;
            endcase
         end
      end
   end

   // Function register lives elsewhere; its read returns zero here
   assign rd_src = (opcode == `FSW_OP_RDSR) ? status_now : 8'h00;

   // Read data shifts out on SCK falls; the index wraps so the byte repeats
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         SO       <= 1'b0;
         SO_OE    <= 1'b0;
         rd_idx   <= 3'h7;
         rd_latch <= 8'h00;
      end
      else
      begin
         SO_OE <= (state == FSW_READ) & ~cs_n_s;
         if (state != FSW_READ)
            rd_idx <= 3'h7;
         else if (sck_fall)
         begin
            if (rd_idx == 3'h7)
            begin
               rd_latch <= rd_src;
               SO       <= rd_src[7];
            end
            else
               SO <= rd_latch[rd_idx];
            rd_idx <= rd_idx - 3'h1;
         end
      end
   end

   // Instruction decisions are made when chip select closes the frame
   assign exec        = cs_end & cmd_got;
   assign sr_locked   = sr_vol[`FSW_BIT_LOCK-2] & ~wp_n_s;
   assign soft_rst    = exec & (opcode == `FSW_OP_SOFT_RESET);
   assign accept_write_enable_cmd = exec & ~write_busy_flag & (opcode == `FSW_OP_WRITE_ENABLE_CMD);
   assign accept_write_disable_cmd = exec & ~write_busy_flag & (opcode == `FSW_OP_WRITE_DISABLE_CMD);
   assign start_sr    = exec & ~write_busy_flag & ~susp & wel & (opcode == `FSW_OP_STATUS_WRITE_CMD)
                        & data_got & ~sr_locked;
   assign start_op    = exec & ~write_busy_flag & ~susp & wel & fsw_needs_wel(opcode)
                        & (opcode != `FSW_OP_STATUS_WRITE_CMD)
                        & ~(fsw_is_chip_erase(opcode)
                            & (sr_vol[3:0] != `FSW_BP_NONE));
   assign do_susp     = exec & write_busy_flag & op_pe & (opcode == `FSW_OP_SUSPEND);
   assign do_resume   = exec & susp & (opcode == `FSW_OP_RESUME);
   assign op_done     = write_busy_flag & (op_cnt == '0);

   // Busy engine; a suspended operation shows ready but keeps its count
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         write_busy_flag    <= 1'b0;
         susp   <= 1'b0;
         op_pe  <= 1'b0;
         op_cnt <= '0;
      end
      else if (soft_rst)
      begin
         write_busy_flag  <= 1'b0;
         susp <= 1'b0;
      end
      else if (do_susp)
      begin
         write_busy_flag  <= 1'b0;
         susp <= 1'b1;
      end
      else if (do_resume)
      begin
         write_busy_flag  <= 1'b1;
         susp <= 1'b0;
      end
      else if (start_sr || start_op)
      begin
         write_busy_flag    <= 1'b1;
         op_pe  <= start_op & fsw_is_prog_erase(opcode);
         op_cnt <= CNT_W'(OP_CYCLES - 1);
      end
      else if (op_done)
         write_busy_flag <= 1'b0;
      else if (write_busy_flag)
         op_cnt <= op_cnt - CNT_W'(1);
   end

   // Write-enable latch; only the enable, disable, reset and completion touch it
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         wel <= 1'b0;
      else if (soft_rst || op_done)
         wel <= 1'b0;
      else if (accept_write_enable_cmd)
         wel <= 1'b1;
      else if (accept_write_disable_cmd)
         wel <= 1'b0;
   end

   // Protect, quad and lock bits: stored copy and working copy
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sr_nv  <= `FSW_SR_FACTORY;
         sr_vol <= `FSW_SR_FACTORY;
      end
      else if (soft_rst)
         sr_vol <= sr_nv;
      else if (start_sr)
      begin
         sr_nv  <= data_byte[7:2];
         sr_vol <= data_byte[7:2];
      end
   end

   // Bit order: lock, quad, protect 3..0, latch, busy
   assign status_now = {sr_vol, wel, write_busy_flag};

   // Registered status view
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         STATUS <= 8'h00;
      else
         STATUS <= status_now;
   end

   // Checks on the decisions above
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_write_enable_cmd_taken;
      exec && !write_busy_flag && (opcode == `FSW_OP_WRITE_ENABLE_CMD);
   endsequence

   sequence s_erase_start;
      exec && !write_busy_flag && !susp && wel && (opcode == `FSW_OP_SER_B);
   endsequence

   a_write_enable_cmd_sets_latch: assert property (s_write_enable_cmd_taken |=> wel)
      else $error("Write-enable did not set the latch");

   a_write_disable_cmd_clears_latch: assert property
      (exec && !write_busy_flag && (opcode == `FSW_OP_WRITE_DISABLE_CMD) |=> !wel)
      else $error("Write-disable did not clear the latch");

   // Enable and disable alike bounce off a busy device
   a_busy_ignores_write_enable_cmd: assert property
      (exec && write_busy_flag && (op_cnt > 1)
       && ((opcode == `FSW_OP_WRITE_ENABLE_CMD) || (opcode == `FSW_OP_WRITE_DISABLE_CMD)) |=> $stable(wel))
      else $error("Latch changed by an instruction taken while busy");

   a_latch_gates_write: assert property
      (exec && !write_busy_flag && !wel && fsw_needs_wel(opcode) |=> !write_busy_flag)
      else $error("Write-type instruction started without the latch");

   a_erase_runs_busy: assert property
      (s_erase_start |=> write_busy_flag [*8])
      else $error("Erase did not hold busy");

   a_done_clears_latch: assert property
      (write_busy_flag && (op_cnt == 0) |=> !write_busy_flag && !wel)
      else $error("Operation end left busy or latch set");

   a_status_lock_holds: assert property
      (exec && (opcode == `FSW_OP_STATUS_WRITE_CMD) && sr_locked |=> $stable(sr_vol) ##1 $stable(sr_nv))
      else $error("Locked status register was written");

   a_chip_erase_guard: assert property
      (exec && !write_busy_flag && fsw_is_chip_erase(opcode) && (sr_vol[3:0] != 0) |=> !write_busy_flag)
      else $error("Chip erase ran with protect bits set");

   a_status_view: assert property
      (1'b1 |=> STATUS == $past(status_now))
      else $error("Status view out of step with the register");

   a_read_drives_out: assert property
      ((state == FSW_READ) && !cs_n_s |=> SO_OE)
      else $error("Read frame not driving the output");

endmodule

// [bench/fsw_host.sv]
// Purpose: Behavioural serial host for the status and write-enable block
// Assumes: Mode 0 framing, SCK period of 8 CLK (400 ns at 20 MHz)
// Notes:   SCK stands low between frames and SI is left at the inverse of its last value
`timescale 1ns/1ps
module fsw_host
   import fsw_pkg::*;
(
   // Time base
   input  wire logic CLK,
   // Device answer
   input  wire logic SO,
   // Link drive
   output logic      SCK,
   output logic      CS_N,
   output logic      SI
);
   // Idle levels from time zero
   initial
   begin
      SCK  = 1'b0;
      CS_N = 1'b1;
      SI   = 1'b0;
   end

   // Select leads the first clock edge by a whole bit
   task automatic open_frame();
      @(negedge CLK);
      CS_N = 1'b0;
      repeat (4) @(negedge CLK);
   endtask

   // SO is taken late in the high phase, well after the device has shifted it
   task automatic xfer(input fsw_byte_t tx, output fsw_byte_t rx);
      for (int i = 7; i >= 0; i--)
      begin
         SCK = 1'b0;
         SI  = tx[i];
         repeat (4) @(negedge CLK);
         SCK = 1'b1;
         repeat (4) @(negedge CLK);
         rx[i] = SO;
      end
   endtask

   // Gap after deselect covers the device's synchroniser
   task automatic close_frame();
      SCK = 1'b0;
      repeat (4) @(negedge CLK);
      CS_N = 1'b1;
      SI   = ~SI;
      repeat (8) @(negedge CLK);
   endtask

   // Whole frame: opcode and optional data byte
   task automatic send(input fsw_byte_t op, input bit has_dat, input fsw_byte_t dat);
      fsw_byte_t junk;
      open_frame();
      xfer(op, junk);
      if (has_dat)
         xfer(dat, junk);
      close_frame();
   endtask
endmodule

// [bench/tb_flash_status_write_enable.sv]
// Purpose: Self-checking bench for the status register and write-enable gate
// Assumes: Busy timer shortened to OPC cycles; all stimulus at falling CLK
// Notes:   Refusals are silent, so every verdict is read from STATUS, SO or SO_OE
`timescale 1ns/1ps
`include "fsw_consts.svh"
module tb_flash_status_write_enable
   import fsw_pkg::*;
;
   localparam int OPC = 400;

   logic       clk;
   logic       rst;
   logic       wp_n;
   logic       sck;
   logic       cs_n;
   logic       si;
   logic       so;
   logic       so_oe;
   logic [7:0] status;
   int         errors;
   int         total_checks;
   fsw_byte_t  op;
   fsw_byte_t  mid;

   // Opcode in the high byte, status expected while it runs in the low byte
   localparam logic [15:0] ROWS [37] = '{
      16'h0203, 16'h1203, 16'h3203, 16'h3803, 16'h3403, 16'h3e03, 16'hd703, 16'h2003,
      16'h2103, 16'h5203, 16'h5c03, 16'hd803, 16'hdc03, 16'hc703, 16'h6003, 16'h4203,
      16'h6503, 16'h8503, 16'h8303, 16'h6403, 16'h6203, 16'h1803, 16'hfb03, 16'he103,
      16'hfd03, 16'he303, 16'he403, 16'h2f03, 16'ha603, 16'h9103, 16'h7e03, 16'h9803,
      16'he803, 16'h4303, 16'h4a03, 16'hc002, 16'h1702};

   fsw_status_wel #(.OP_CYCLES(OPC)) u_dut
   (
      .CLK    (clk),
      .RST    (rst),
      .SCK    (sck),
      .CS_N   (cs_n),
      .SI     (si),
      .WP_N   (wp_n),
      .SO     (so),
      .SO_OE  (so_oe),
      .STATUS (status)
   );

   fsw_host u_host
   (
      .CLK  (clk),
      .SO   (so),
      .SCK  (sck),
      .CS_N (cs_n),
      .SI   (si)
   );

   // 20 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check_byte(input fsw_byte_t got, input fsw_byte_t exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmd(input fsw_byte_t code);
      u_host.send(code, 1'b0, 8'h00);
   endtask

   // Long enough for any busy period to run out
   task automatic wait_op();
      repeat (OPC + 50) @(negedge clk);
   endtask

   // Read a register for n bytes while select stays low
   task automatic read_status(input fsw_byte_t code, input int n, input fsw_byte_t exp);
      fsw_byte_t rx;
      u_host.open_frame();
      u_host.xfer(code, rx);
      for (int k = 0; k < n; k++)
      begin
         u_host.xfer(8'h00, rx);
         check_byte(rx, exp, "read byte");
      end
      check_bit(so_oe, 1'b1, "drive on");
      u_host.close_frame();
      check_bit(so_oe, 1'b0, "drive off");
   endtask

   // Hang guard, well beyond the expected 33k cycles
   initial
   begin
      #4_000_000;
      errors++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      errors       = 0;
      total_checks = 0;
      rst          = 1'b1;
      wp_n         = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      check_byte(status, 8'h00, "reset");
      check_bit(so_oe, 1'b0, "reset drive");
      // Every latch-gated code but status write refused, then run after write enable
      foreach (ROWS[r])
      begin
         op  = ROWS[r][15:8];
         mid = ROWS[r][7:0];
         cmd(op);
         check_byte(status, 8'h00, "no latch");
         cmd(`FSW_OP_WRITE_ENABLE_CMD);
         cmd(op);
         check_byte(status, mid, "running");
         wait_op();
         check_byte(status, mid[0] ? 8'h00 : 8'h02, "ended");
         cmd(`FSW_OP_WRITE_DISABLE_CMD);
         check_byte(status, 8'h00, "disabled");
      end
      // Status write: refused, then taken with low bits ignored
      u_host.send(`FSW_OP_STATUS_WRITE_CMD, 1'b1, 8'hbf);
      check_byte(status, 8'h00, "status_write_cmd refused");
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      u_host.send(`FSW_OP_STATUS_WRITE_CMD, 1'b1, 8'hbf);
      check_byte(status & 8'h03, 8'h03, "status_write_cmd busy");
      wait_op();
      check_byte(status, 8'hbc, "status_write_cmd done");
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      cmd(`FSW_OP_CER_A);
      check_byte(status, 8'hbe, "chip erase held");
      read_status(`FSW_OP_RDSR, 3, 8'hbe);
      // Lock with write-protect low, then released
      wp_n = 1'b0;
      u_host.send(`FSW_OP_STATUS_WRITE_CMD, 1'b1, 8'h40);
      wait_op();
      check_byte(status, 8'hbe, "locked");
      wp_n = 1'b1;
      u_host.send(`FSW_OP_STATUS_WRITE_CMD, 1'b1, 8'h40);
      wait_op();
      check_byte(status, 8'h40, "unlocked");
      // Busy filter: reads pass, write-disable is ignored
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      cmd(`FSW_OP_SER_B);
      read_status(`FSW_OP_RDSR, 1, 8'h43);
      cmd(`FSW_OP_WRITE_DISABLE_CMD);
      check_byte(status, 8'h43, "disable ignored");
      wait_op();
      check_byte(status, 8'h40, "erase done");
      // Suspend and resume mid-erase
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      cmd(`FSW_OP_SER_B);
      cmd(`FSW_OP_SUSPEND);
      check_byte(status, 8'h42, "suspended");
      cmd(`FSW_OP_RESUME);
      check_byte(status, 8'h43, "resumed");
      wait_op();
      check_byte(status, 8'h40, "resume done");
      // Function read and soft reset both pass a busy device
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      cmd(`FSW_OP_SER_B);
      read_status(`FSW_OP_RDFR, 1, 8'h00);
      cmd(`FSW_OP_SOFT_RESET);
      check_byte(status, 8'h40, "soft reset");
      // Reset in mid-erase stands for power-on: stored bits clear as well
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      cmd(`FSW_OP_SER_B);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      check_byte(status, 8'h00, "mid reset");
      check_bit(so_oe, 1'b0, "mid reset drive");
      cmd(`FSW_OP_WRITE_ENABLE_CMD);
      check_byte(status, 8'h02, "first after reset");
      print_verdict();
   end
endmodule
